// ==== shared/mse_pkg.sv ====
`default_nettype none

package mse_pkg;

  // Function codes the slave serves
  localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
  localparam logic [7:0]  FC_RD_INPUT   = 8'h04;
  localparam logic [7:0]  FC_WR_SINGLE  = 8'h06;
  localparam logic [7:0]  FC_WR_MULTI   = 8'h10;

  // Exception codes
  localparam logic [7:0]  EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0]  EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0]  EXC_ILL_VALUE = 8'h03;
  localparam logic [7:0]  EXC_DEV_FAIL  = 8'h04;
  localparam logic [7:0]  EXC_ACK_LONG  = 8'h05;
  localparam logic [7:0]  EXC_BUSY      = 8'h06;
  localparam logic [7:0]  EXC_PARITY    = 8'h08;
  localparam logic [7:0]  EXC_FLAG_MASK = 8'h80;
  localparam logic [7:0]  EXC_NONE      = 8'h00;

  // Stand-in value for a parameter that does not exist
  localparam logic [15:0] NOEXIST_VALUE = 16'h7533;

  // Largest register counts per query
  localparam logic [7:0]  MAX_RD_COUNT  = 8'h7D;
  localparam logic [7:0]  MAX_WR_COUNT  = 8'h7B;

  localparam logic [15:0] DROP_CNT_RST  = 16'h0000;

  typedef enum logic [1:0] {
    RSP_NONE   = 2'b00,
    RSP_NORMAL = 2'b01,
    RSP_EXC    = 2'b10
  } mse_rsp_kind_t;

  typedef struct packed {
    logic        crc_ok;
    logic [7:0]  slave_id;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [7:0]  count;
    logic [15:0] wdata;
  } mse_query_t;

  typedef struct packed {
    logic        exists;
    logic        read_only;
    logic        in_range;
    logic [15:0] rdata;
  } mse_lookup_t;

  typedef struct packed {
    logic dev_fail;
    logic parity_err;
    logic busy;
    logic long_ack;
  } mse_status_t;

  typedef struct packed {
    logic          valid;
    mse_rsp_kind_t kind;
    logic [7:0]    func;
    logic [7:0]    exc_code;
    logic [15:0]   data;
  } mse_reply_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  count;
    logic [15:0] data;
  } mse_commit_t;

  typedef struct packed {
    mse_reply_t  rsp;
    mse_commit_t cmt;
    logic [15:0] dropped;
  } mse_state_t;

endpackage : mse_pkg

`default_nettype wire

// ==== rtl/mse_responder.sv ====
// Behaviour
// - Corrupted query gets no reply at all; master times out.
// - Valid query gets a normal reply echoing the function code.
// - Exceptions: unsupported function 01, bad address 02, bad value 03.
// - Exceptions: device failure 04, long acknowledge 05, busy 06, parity 08.
// - Reading an invalid parameter returns a number, never an error.
// - Write to missing or read-only parameter is dropped, normal reply.
// - Write to read-only register is dropped, contents unchanged, no error.
// - Write reaching any register out of range gets exception 02.
// - Read of a missing parameter returns 30003.
// - Writes take effect only while remote control is enabled.
`timescale 1ns/1ps
`default_nettype none

module mse_responder
  import mse_pkg::*;
(
  input  wire logic        mclk_i,        // System clock, 50 MHz
  input  wire logic        sys_rst_i,     // Synchronous reset, active high
  input  wire logic        q_valid_i,     // One-cycle pulse: parsed query
  input  wire mse_query_t  q_i,           // Parsed query fields
  input  wire mse_lookup_t lookup_i,      // Parameter map answer for q_i
  input  wire mse_status_t status_i,      // Device condition flags
  input  wire logic [7:0]  node_id_i,     // Own slave identifier
  input  wire logic        remote_control_enable_i, // Remote writes allowed
  output logic             rsp_valid_o,   // One-cycle pulse: send reply
  output mse_reply_t       rsp_o,         // Reply content
  output mse_commit_t      commit_o,      // One-cycle pulse: store write
  output logic [15:0]      dropped_cnt_o  // Corrupted queries dropped
);

  function automatic logic is_write(input logic [7:0] fc);
    is_write = (fc == FC_WR_SINGLE) || (fc == FC_WR_MULTI);
  endfunction : is_write

  function automatic logic is_read(input logic [7:0] fc);
    is_read = (fc == FC_RD_HOLD) || (fc == FC_RD_INPUT);
  endfunction : is_read

  mse_state_t s_q;
  mse_state_t s_d;

  logic for_me;
  logic fc_ok;
  logic cnt_ok;
  logic fault;

  // Quantities also used by the checks below
  always_comb begin
    for_me = q_valid_i && q_i.crc_ok && (q_i.slave_id == node_id_i);
    fc_ok  = is_read(q_i.func) || is_write(q_i.func);
    if (q_i.func == FC_WR_SINGLE) begin
      cnt_ok = 1'b1;
    end else if (q_i.func == FC_WR_MULTI) begin
      cnt_ok = (q_i.count != 8'h00) && (q_i.count <= MAX_WR_COUNT);
    end else begin
      cnt_ok = (q_i.count != 8'h00) && (q_i.count <= MAX_RD_COUNT);
    end
    fault = status_i.dev_fail || status_i.parity_err || status_i.busy || status_i.long_ack;
  end

  always_comb begin
    s_d               = s_q;
    s_d.rsp.valid     = 1'b0;
    s_d.cmt.valid     = 1'b0;
    if (q_valid_i && !q_i.crc_ok) begin
      // Silence is the only answer; the master's timeout drives the retry
      s_d.dropped = s_q.dropped + 16'h0001;
    end else if (for_me) begin
      s_d.rsp.valid    = 1'b1;
      s_d.rsp.kind     = RSP_NORMAL;
      s_d.rsp.func     = q_i.func;
      s_d.rsp.exc_code = EXC_NONE;
      s_d.rsp.data     = lookup_i.rdata;
      if (!fc_ok) begin
        s_d.rsp.kind     = RSP_EXC;
        s_d.rsp.exc_code = EXC_ILL_FUNC;
      end else if (!cnt_ok) begin
        s_d.rsp.kind     = RSP_EXC;
        s_d.rsp.exc_code = EXC_ILL_VALUE;
      end else if (is_write(q_i.func) && !lookup_i.in_range) begin
        s_d.rsp.kind     = RSP_EXC;
        s_d.rsp.exc_code = EXC_ILL_ADDR;
      end else if (status_i.dev_fail) begin
        s_d.rsp.kind     = RSP_EXC;
        s_d.rsp.exc_code = EXC_DEV_FAIL;
      end else if (status_i.parity_err) begin
        s_d.rsp.kind     = RSP_EXC;
        s_d.rsp.exc_code = EXC_PARITY;
      end else if (status_i.busy) begin
        s_d.rsp.kind     = RSP_EXC;
        s_d.rsp.exc_code = EXC_BUSY;
      end else if (status_i.long_ack) begin
        s_d.rsp.kind     = RSP_EXC;
        s_d.rsp.exc_code = EXC_ACK_LONG;
      end else if (is_read(q_i.func)) begin
        // Reads never fail on a bad parameter, so old masters keep polling
        if (!lookup_i.exists) begin
          s_d.rsp.data = NOEXIST_VALUE;
        end
      end else begin
        // Bad targets and a locked-out remote are swallowed without error
        if (lookup_i.exists && !lookup_i.read_only && remote_control_enable_i) begin
          s_d.cmt.valid = 1'b1;
          s_d.cmt.addr  = q_i.addr;
          s_d.cmt.count = q_i.count;
          s_d.cmt.data  = q_i.wdata;
        end
      end
      if (s_d.rsp.kind == RSP_EXC) begin
        s_d.rsp.func = q_i.func | EXC_FLAG_MASK;
        s_d.rsp.data = {8'h00, s_d.rsp.exc_code};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_q <= '{rsp: '{valid: 1'b0, kind: RSP_NONE, func: 8'h00, exc_code: EXC_NONE, data: 16'h0000},
               cmt: '{valid: 1'b0, addr: 16'h0000, count: 8'h00, data: 16'h0000},
               dropped: DROP_CNT_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_valid_o   = s_q.rsp.valid;
  assign rsp_o         = s_q.rsp;
  assign commit_o      = s_q.cmt;
  assign dropped_cnt_o = s_q.dropped;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_good_query;
    for_me && fc_ok && cnt_ok;
  endsequence

  sequence s_clean_device;
    !fault;
  endsequence

  sequence s_target_ok;
    is_read(q_i.func) || lookup_i.in_range;
  endsequence

  property p_corrupt_silent;
    q_valid_i && !q_i.crc_ok |=> !rsp_valid_o && (dropped_cnt_o == $past(dropped_cnt_o) + 16'h0001);
  endproperty
  a_corrupt_silent: assert property (p_corrupt_silent) else $error("reply sent to corrupted query");

  property p_normal_echo;
    (s_good_query and s_clean_device) ##0 (is_read(q_i.func) || lookup_i.in_range)
      |=> rsp_valid_o && rsp_o.kind == RSP_NORMAL && rsp_o.func == $past(q_i.func);
  endproperty
  a_normal_echo: assert property (p_normal_echo) else $error("valid query lacks normal echo");

  property p_bad_func;
    for_me && !fc_ok |=> rsp_valid_o && rsp_o.exc_code == EXC_ILL_FUNC;
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("unsupported function not code 01");

  property p_bad_count;
    for_me && fc_ok && !cnt_ok |=> rsp_o.kind == RSP_EXC && rsp_o.exc_code == EXC_ILL_VALUE;
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("bad count not code 03");

  property p_dev_fail;
    s_good_query ##0 (is_read(q_i.func) || lookup_i.in_range) ##0 status_i.dev_fail
      |=> rsp_o.kind == RSP_EXC && rsp_o.exc_code == EXC_DEV_FAIL;
  endproperty
  a_dev_fail: assert property (p_dev_fail) else $error("device failure not code 04");

  // Lesser faults only speak when no graver one is pending
  property p_parity;
    s_good_query ##0 s_target_ok ##0 (!status_i.dev_fail && status_i.parity_err)
      |=> rsp_valid_o && rsp_o.kind == RSP_EXC && rsp_o.exc_code == EXC_PARITY;
  endproperty
  a_parity: assert property (p_parity) else $error("parity fault not code 08");

  property p_busy;
    s_good_query ##0 s_target_ok ##0 (!status_i.dev_fail && !status_i.parity_err && status_i.busy)
      |=> rsp_valid_o && rsp_o.kind == RSP_EXC && rsp_o.exc_code == EXC_BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("busy device not code 06");

  property p_long_ack;
    s_good_query ##0 s_target_ok
      ##0 (!status_i.dev_fail && !status_i.parity_err && !status_i.busy && status_i.long_ack)
      |=> rsp_valid_o && rsp_o.kind == RSP_EXC && rsp_o.exc_code == EXC_ACK_LONG;
  endproperty
  a_long_ack: assert property (p_long_ack) else $error("long request not code 05");

  property p_missing_read;
    (s_good_query and s_clean_device) ##0 is_read(q_i.func) ##0 !lookup_i.exists
      |=> rsp_o.kind == RSP_NORMAL && rsp_o.data == NOEXIST_VALUE;
  endproperty
  a_missing_read: assert property (p_missing_read) else $error("missing parameter read not 30003");

  property p_ro_write_dropped;
    for_me && is_write(q_i.func) && (lookup_i.read_only || !lookup_i.exists)
      |=> !commit_o.valid;
  endproperty
  a_ro_write_dropped: assert property (p_ro_write_dropped) else $error("read-only write was stored");

  // Swallowed writes still earn a normal reply, so the master sees no error
  property p_bad_target_quiet;
    (s_good_query and s_clean_device) ##0 is_write(q_i.func) ##0 lookup_i.in_range
      ##0 (lookup_i.read_only || !lookup_i.exists)
      |=> rsp_valid_o && rsp_o.kind == RSP_NORMAL && !commit_o.valid;
  endproperty
  a_bad_target_quiet: assert property (p_bad_target_quiet) else $error("bad target write not quiet");

  property p_range_write;
    s_good_query ##0 is_write(q_i.func) ##0 !lookup_i.in_range
      |=> rsp_o.exc_code == EXC_ILL_ADDR && !commit_o.valid;
  endproperty
  a_range_write: assert property (p_range_write) else $error("out-of-range write not code 02");

  property p_remote_gate;
    commit_o.valid |-> $past(remote_control_enable_i) && $past(for_me);
  endproperty
  a_remote_gate: assert property (p_remote_gate) else $error("write stored without remote enable");

  property p_exc_format;
    rsp_valid_o && rsp_o.kind == RSP_EXC |-> rsp_o.func[7] && rsp_o.data[7:0] == rsp_o.exc_code;
  endproperty
  a_exc_format: assert property (p_exc_format) else $error("exception reply badly formed");

  property p_foreign_id;
    q_valid_i && q_i.slave_id != node_id_i |=> !rsp_valid_o && !commit_o.valid;
  endproperty
  a_foreign_id: assert property (p_foreign_id) else $error("reply to foreign identifier");

endmodule : mse_responder

`default_nettype wire

// ==== verification/mse_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mse_master_model
  import mse_pkg::*;
#(
  parameter int TMO = 4
) (
  input  wire logic       mclk_i,      // System clock
  input  wire logic       sys_rst_i,   // Synchronous reset
  input  wire logic       send_i,      // Bench asks for a query
  input  wire mse_query_t qry_i,       // Query to send
  input  wire logic       rsp_valid_i, // Slave replied
  output logic            q_valid_o,   // Query pulse
  output mse_query_t      q_o,         // Query fields
  output logic [3:0]      retry_o      // Resends since last query
);
  mse_query_t last_q;
  int         wait_c;
  always_ff @(posedge mclk_i) begin
    q_valid_o <= 1'b0;
    q_o       <= ~last_q; // Idle lines show junk, not the old query
    if (sys_rst_i) begin
      wait_c  <= 0;
      retry_o <= 4'h0;
      last_q  <= '0;
    end else if (send_i) begin
      last_q    <= qry_i;
      q_o       <= qry_i;
      q_valid_o <= 1'b1;
      wait_c    <= TMO;
      retry_o   <= 4'h0;
    end else if (rsp_valid_i) begin
      wait_c <= 0;
    end else if (wait_c == 1) begin
      q_o       <= last_q;
      q_valid_o <= 1'b1;
      retry_o   <= retry_o + 4'h1;
      wait_c    <= 0;
    end else if (wait_c > 1) begin
      wait_c <= wait_c - 1;
    end
  end
endmodule : mse_master_model
`default_nettype wire

// ==== verification/mse_responder_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module mse_responder_bench;
  import mse_pkg::*;
  logic        mclk_i = 0, sys_rst_i = 1, send = 0, rce = 0, qv, rv;
  logic [7:0]  node = 8'h11;
  mse_query_t  qry = '0, qd;
  mse_lookup_t lk = '0;
  mse_status_t st = '0;
  mse_reply_t  rsp;
  mse_commit_t cmt;
  logic [15:0] drp;
  logic [3:0]  rty;
  // Mostly served codes; two unsupported ones only probe exception 01
  logic [7:0]  fl[6] = '{FC_RD_HOLD, FC_RD_INPUT, FC_WR_SINGLE, FC_WR_MULTI, 8'h2B, 8'h01};
  int n_mismatch = 0, checks_done = 0, cyc = 0, seed = 32'hd89d_4681, ndrop = 0;
  always #10 mclk_i = ~mclk_i;
  mse_master_model #(.TMO(4)) mst_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .send_i(send), .qry_i(qry),
    .rsp_valid_i(rv), .q_valid_o(qv), .q_o(qd), .retry_o(rty));
  mse_responder dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .q_valid_i(qv), .q_i(qd), .lookup_i(lk),
    .status_i(st), .node_id_i(node), .remote_control_enable_i(rce), .rsp_valid_o(rv), .rsp_o(rsp),
    .commit_o(cmt), .dropped_cnt_o(drp));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic test_done();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  // Ceiling well above 400 queries of about ten cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 10000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    mse_query_t q;
    mse_lookup_t l;
    mse_status_t s;
    logic wr, rd, sil, cm, r;
    logic [7:0] ex;
    logic [63:0] rw;
    logic [15:0] xd;
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk("rsp_valid", rv, 0);
    chk("drop_cnt", drp, 0);
    for (int i = 0; i < 400; i++) begin
      rw = {$random(seed), $random(seed)};
      q = rw[56:0];
      rw = {$random(seed), $random(seed)};
      q.crc_ok = rw[2:0] != 3'b000;
      q.slave_id = (rw[5:3] != 3'b000) ? node : node + 8'h01;
      q.func = fl[rw[8:6] % 3'd6];
      q.count = (rw[10:9] != 2'b00) ? {1'b0, rw[17:11]} : rw[25:18];
      s = (rw[27:26] == 2'b00) ? rw[31:28] : 4'h0;
      r = rw[32];
      l = rw[51:33];
      @(posedge mclk_i);
      send <= 1'b1;
      qry <= q;
      lk <= l;
      st <= s;
      rce <= r;
      @(posedge mclk_i);
      send <= 1'b0;
      @(posedge mclk_i);
      #1;
      rd = q.func == FC_RD_HOLD || q.func == FC_RD_INPUT;
      wr = q.func == FC_WR_SINGLE || q.func == FC_WR_MULTI;
      sil = !q.crc_ok || q.slave_id != node;
      ex = !(rd || wr) ? EXC_ILL_FUNC :
           (rd && (q.count < 1 || q.count > MAX_RD_COUNT)) ? EXC_ILL_VALUE :
           (q.func == FC_WR_MULTI && (q.count < 1 || q.count > MAX_WR_COUNT)) ? EXC_ILL_VALUE :
           (wr && !l.in_range) ? EXC_ILL_ADDR : s.dev_fail ? EXC_DEV_FAIL : s.parity_err ? EXC_PARITY :
           s.busy ? EXC_BUSY : s.long_ack ? EXC_ACK_LONG : EXC_NONE;
      cm = !sil && ex == EXC_NONE && wr && l.exists && !l.read_only && r;
      if (!q.crc_ok) ndrop += 2;
      chk("rsp_valid", rv, !sil);
      chk("rsp_o_valid", rsp.valid, !sil);
      if (!sil) begin
        chk("kind", rsp.kind, (ex != EXC_NONE) ? RSP_EXC : RSP_NORMAL);
        chk("func", rsp.func, (ex != EXC_NONE) ? (q.func | EXC_FLAG_MASK) : q.func);
        chk("exc_code", rsp.exc_code, ex);
        xd = (ex != EXC_NONE) ? {8'h00, ex} : (rd && !l.exists) ? NOEXIST_VALUE : l.rdata;
        chk("data", rsp.data, xd);
      end
      chk("commit_valid", cmt.valid, cm);
      if (cm) begin
        chk("commit_addr", cmt.addr, q.addr);
        chk("commit_data", cmt.data, q.wdata);
        if (q.func == FC_WR_MULTI) chk("commit_count", cmt.count, q.count);
      end
      repeat (6) @(posedge mclk_i);
      #1;
      chk("retry", rty, sil);
      chk("drop_cnt", drp, ndrop);
    end
    test_done();
  end
endmodule : mse_responder_bench
`default_nettype wire
